// ---- bench/iec_src_model.sv ----
// model of the interrupt sources around the block
// assumes the bench clock; drives right after rising edges
`timescale 1ns/100ps
`default_nettype none
module iec_src_model (
    input wire logic clock,
    output logic tick,
    output logic pin,
    output logic pc,
    output logic [7:0] pf
);
    initial begin
        tick = 1'b0;
        pin = 1'b0;
        pc = 1'b0;
        pf = 8'h00;
    end
    // single-cycle pulses, a held level would count every cycle
    task automatic pulse_tick;
        @(posedge clock);
        tick <= 1'b1;
        @(posedge clock);
        tick <= 1'b0;
    endtask
    task automatic pulse_pc;
        @(posedge clock);
        pc <= 1'b1;
        @(posedge clock);
        pc <= 1'b0;
    endtask
    task automatic set_pin(input logic v);
        @(posedge clock);
        pin <= v;
    endtask
    task automatic set_pf(input logic [7:0] v);
        @(posedge clock);
        pf <= v;
    endtask
endmodule
`default_nettype wire

// ---- bench/iec_top_sva.sv ----
// checker on the ports of the interrupt enable control block
// assumes one clock domain and a bind onto iec_top
`timescale 1ns/100ps
`default_nettype none
module iec_top_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] periph_flags,
    input wire logic core_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    chk_write_seq: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
    chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000)
        else $error("error read carries data");
    // flags never clear by hardware, so a drop needs a write or a peripheral flag going low
    chk_irq_fall: assert property ($fell(core_irq) |-> $past(s_axi_bvalid) ||
        ($past(periph_flags, 2) & ~$past(periph_flags)) != 8'h00) else $error("request fell without cause");
endmodule
bind iec_top iec_top_sva chk_i (.clock(clock), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .periph_flags(periph_flags), .core_irq(core_irq));
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the interrupt enable control block
// assumes iec_top, its bound checker and the source model
`timescale 1ns/100ps
`default_nettype none
`include "iec_consts.vh"
module testbench;
    localparam logic [11:0] A_LO = {`IEC_IDX_INTCTL_LO, 2'b00};
    localparam logic [11:0] A_HI = {`IEC_IDX_INTCTL_HI, 2'b00};
    localparam logic [11:0] A_PIE = {`IEC_IDX_PIE, 2'b00};
    localparam logic [11:0] A_CFG = {`IEC_IDX_CONFIG, 2'b00};
    localparam logic [11:0] A_ST = {`IEC_IDX_STATUS, 2'b00};
    localparam logic [11:0] A_MSK = {`IEC_IDX_MASK, 2'b00};
    localparam logic [11:0] A_TMR = {`IEC_IDX_TIMER, 2'b00};
    logic clock = 1'b0, rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_irq, irq, tick, pin, pc;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] pf;
    int n_mismatch = 0, comparisons = 0;
    always #5 clock = ~clock;
    iec_top dut (.clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_zero_tick(tick), .external_irq_pin(pin),
        .port_change_event(pc), .periph_flags(pf), .core_irq(core_irq), .irq(irq));
    iec_src_model src (.clock(clock), .tick(tick), .pin(pin), .pc(pc), .pf(pf));
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 40) begin
            n_mismatch++;
            $display("[ERR] %0t bus answer missing", $time);
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = `IEC_RESP_OKAY,
        input logic [3:0] s = 4'hf);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        hang(n);
        chk(s_axi_bresp, r);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = `IEC_RESP_OKAY);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        hang(n);
        chk(s_axi_rdata, {24'h00_0000, d});
        chk(s_axi_rresp, r);
        s_axi_rready <= 1'b0;
    endtask
    task automatic st;
        repeat (5) @(posedge clock);
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd(A_LO, 8'h00);
        rd(A_PIE, 8'h00);
        rd(A_ST, 8'h00);
        wr(A_LO, 8'h18);
        rd(A_HI, 8'h18);
        wr(A_PIE, 8'hff);
        rd(A_PIE, 8'hc9);
        wr(12'h3f0, 8'h55, `IEC_RESP_SLVERR);
        rd(12'h3f0, 8'h00, `IEC_RESP_SLVERR);
        wr(A_HI, 8'h00);
        src.pulse_pc();
        st();
        rd(A_LO, 8'h01);
        rd(A_ST, 8'h04);
        chk(core_irq, 0);
        wr(A_LO, 8'h89);
        st();
        chk(core_irq, 1);
        wr(A_LO, 8'h88);
        st();
        chk(core_irq, 0);
        wr(A_LO, 8'h80);
        src.set_pf(8'h01);
        st();
        chk(core_irq, 0);
        wr(A_LO, 8'hc0);
        for (int i = 0; i < 8; i++) begin
            src.set_pf(8'h01 << i);
            st();
            chk(core_irq, (`IEC_PIE_WMASK >> i) & 1);
        end
        src.set_pf(8'h00);
        wr(A_MSK, 8'h01);
        // byte lane 0 off: answered but nothing written
        wr(A_MSK, 8'h07, `IEC_RESP_OKAY, 4'h0);
        rd(A_MSK, 8'h01);
        wr(A_TMR, 8'hff);
        wr(A_LO, 8'ha0);
        src.pulse_tick();
        st();
        chk(core_irq, 1);
        chk(irq, 1);
        rd(A_ST, 8'h05);
        rd(A_LO, 8'ha4);
        rd(A_TMR, 8'h00);
        wr(A_LO, 8'h84);
        st();
        chk(core_irq, 0);
        wr(A_ST, 8'h01);
        st();
        chk(irq, 0);
        rd(A_ST, 8'h04);
        // rising edge first, since the pin idles low
        for (int e = 1; e >= 0; e--) begin
            wr(A_CFG, e[7:0]);
            rd(A_CFG, e[7:0]);
            wr(A_LO, 8'h90);
            src.set_pin(e[0]);
            st();
            rd(A_LO, 8'h92);
            chk(core_irq, 1);
            chk(irq, 0);
            wr(A_LO, 8'h82);
            st();
            chk(core_irq, 0);
        end
        wr(A_LO, 8'hc2);
        src.set_pf(8'h08);
        st();
        chk(core_irq, 1);
        wr(A_LO, 8'h5a);
        st();
        chk(core_irq, 0);
        src.set_pf(8'h00);
        wr(A_TMR, 8'h5a);
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        rd(A_TMR, 8'h5a);
        rd(A_LO, 8'h00);
        rd(A_PIE, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- rtl/iec_consts.vh ----
// constants of the interrupt enable control block
// assumes a 32-bit axi4-lite bus, word index = byte address / 4
`ifndef IEC_CONSTS_VH
`define IEC_CONSTS_VH

`define IEC_ADDR_W 12
`define IEC_IDX_W 10

// register indices, byte address is four times the index
`define IEC_IDX_INTCTL_LO 10'h00b
`define IEC_IDX_INTCTL_HI 10'h08b
`define IEC_IDX_PIE 10'h08c
`define IEC_IDX_CONFIG 10'h100
`define IEC_IDX_STATUS 10'h101
`define IEC_IDX_MASK 10'h102
`define IEC_IDX_TIMER 10'h103

// interrupt_control field positions
`define IEC_GLOBAL_EN_BIT 7
`define IEC_GROUP_EN_BIT 6
`define IEC_T0_EN_BIT 5
`define IEC_EXTIE_BIT 4
`define IEC_PCIE_BIT 3
`define IEC_T0_FLAG_BIT 2
`define IEC_EXTIF_BIT 1
`define IEC_PCIF_BIT 0
`define IEC_NUM_CORE_SRC 3

// peripheral_interrupt_enable implemented bits
`define IEC_PIE_WMASK 8'hc9
`define IEC_INTCTL_RESET 8'h00
`define IEC_PIE_RESET 8'h00

// config register fields
`define IEC_EDGE_SEL_BIT 0
`define IEC_CONFIG_RESET 1'b0

// status and mask registers, one bit per event
`define IEC_EVT_T0 0
`define IEC_EVT_EXT 1
`define IEC_EVT_PC 2
`define IEC_EVT_W 3
`define IEC_STATUS_RESET 3'h0
`define IEC_MASK_RESET 3'h0

// axi responses
`define IEC_RESP_OKAY 2'h0
`define IEC_RESP_SLVERR 2'h2

`define IEC_TIMER_MAX 8'hff

`endif

// ---- rtl/iec_timer_zero.v ----
// timer-zero count and its rollover pulse
// assumes tick is a one-cycle pulse synchronous to clock
`timescale 1ns/100ps
`default_nettype none
`include "iec_consts.vh"

module iec_timer_zero (
    input wire clock,
    input wire rst,
    input wire tick,
    input wire load_en,
    input wire [7:0] load_value,
    output reg [7:0] count,
    output reg ovf
);

    // count is deliberately kept out of reset so its value survives one
    always @(posedge clock) begin
        if (load_en) begin
            count <= load_value;
        end else if (tick) begin
            count <= count + 8'h01;
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ovf <= 1'b0;
        end else begin
            ovf <= tick && !load_en && (count == `IEC_TIMER_MAX);
        end
    end

endmodule
`default_nettype wire

// ---- rtl/iec_top.v ----
// interrupt enable control: control/enable registers, flags, core request
// assumes a synchronous axi4-lite master and sources synchronous to clock
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "iec_consts.vh"

module iec_top (
    input wire clock,
    input wire rst,
    input wire [`IEC_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`IEC_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire timer_zero_tick,
    input wire external_irq_pin,
    input wire port_change_event,
    input wire [7:0] periph_flags,
    output reg core_irq,
    output reg irq
);

    reg [7:0] interrupt_control;
    reg [7:0] peripheral_interrupt_enable;
    reg ext_edge_select;
    reg [`IEC_EVT_W-1:0] event_status;
    reg [`IEC_EVT_W-1:0] event_mask;
    reg aw_full;
    reg w_full;
    reg [`IEC_IDX_W-1:0] aw_idx;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg pin_prev;
    reg pin_primed;

    wire [7:0] timer_zero_count;
    wire timer_zero_ovf;
    wire hs_aw;
    wire hs_w;
    wire hs_ar;
    wire do_write;
    wire wr_low;
    wire wr_intctl;
    wire wr_pie;
    wire wr_config;
    wire wr_status;
    wire wr_mask;
    wire wr_timer;
    wire ext_edge;
    wire [`IEC_NUM_CORE_SRC-1:0] core_set;
    wire [`IEC_NUM_CORE_SRC-1:0] core_gated;
    wire [`IEC_IDX_W-1:0] ar_idx;
    wire [`IEC_EVT_W-1:0] evt_set;
    wire core_term;
    wire periph_term;
    wire next_core_irq;
    reg next_aw_full;
    reg next_w_full;
    reg next_rvalid;
    reg [31:0] next_rdata;
    reg [1:0] next_rresp;

    assign hs_aw = s_axi_awvalid && s_axi_awready;
    assign hs_w = s_axi_wvalid && s_axi_wready;
    assign hs_ar = s_axi_arvalid && s_axi_arready;
    // write fires once both halves are held and the last answer was taken
    assign do_write = aw_full && w_full && !s_axi_bvalid;
    assign wr_low = do_write && w_strb[0];
    assign wr_intctl = wr_low && ((aw_idx == `IEC_IDX_INTCTL_LO) || (aw_idx == `IEC_IDX_INTCTL_HI));
    assign wr_pie = wr_low && (aw_idx == `IEC_IDX_PIE);
    assign wr_config = wr_low && (aw_idx == `IEC_IDX_CONFIG);
    assign wr_status = wr_low && (aw_idx == `IEC_IDX_STATUS);
    assign wr_mask = wr_low && (aw_idx == `IEC_IDX_MASK);
    assign wr_timer = wr_low && (aw_idx == `IEC_IDX_TIMER);
    assign ar_idx = s_axi_araddr[`IEC_ADDR_W-1:2];

    // a new handshake outranks the release of its slot in the same cycle
    always @* begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_rvalid = s_axi_rvalid;
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
        end
        if (hs_aw) begin
            next_aw_full = 1'b1;
        end
        if (hs_w) begin
            next_w_full = 1'b1;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (hs_ar) begin
            next_rvalid = 1'b1;
        end
    end

    iec_timer_zero u_timer_zero (
        .clock(clock),
        .rst(rst),
        .tick(timer_zero_tick),
        .load_en(wr_timer),
        .load_value(w_data[7:0]),
        .count(timer_zero_count),
        .ovf(timer_zero_ovf)
    );

    // no edge is reported until the pin has been sampled once after reset
    assign ext_edge = pin_primed && (ext_edge_select ? (external_irq_pin && !pin_prev)
                                                     : (!external_irq_pin && pin_prev));

    assign core_set[`IEC_T0_FLAG_BIT] = timer_zero_ovf;
    assign core_set[`IEC_EXTIF_BIT] = ext_edge;
    assign core_set[`IEC_PCIF_BIT] = port_change_event;

    // status bit order differs from the flag order, so route each event by name
    assign evt_set[`IEC_EVT_T0] = timer_zero_ovf;
    assign evt_set[`IEC_EVT_EXT] = ext_edge;
    assign evt_set[`IEC_EVT_PC] = port_change_event;

    // each core flag is paired with the enable three bits above it
    genvar g;
    generate
        for (g = 0; g < `IEC_NUM_CORE_SRC; g = g + 1) begin : gen_core_src
            assign core_gated[g] = interrupt_control[g] && interrupt_control[g + 3];
        end
    endgenerate

    // group enable only reaches the peripheral half of the request
    assign core_term = |core_gated;
    assign periph_term = interrupt_control[`IEC_GROUP_EN_BIT] &&
                         (|(peripheral_interrupt_enable & periph_flags));
    assign next_core_irq = interrupt_control[`IEC_GLOBAL_EN_BIT] &&
                           (core_term || periph_term);

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_prev <= 1'b0;
            pin_primed <= 1'b0;
        end else begin
            pin_prev <= external_irq_pin;
            pin_primed <= 1'b1;
        end
    end

    // flags: hardware set wins over a same-cycle write of zero
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            interrupt_control <= `IEC_INTCTL_RESET;
        end else begin
            if (wr_intctl) begin
                interrupt_control[7:3] <= w_data[7:3];
            end
            interrupt_control[2:0] <= core_set | (wr_intctl ? w_data[2:0] : interrupt_control[2:0]);
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            peripheral_interrupt_enable <= `IEC_PIE_RESET;
            ext_edge_select <= `IEC_CONFIG_RESET;
            event_mask <= `IEC_MASK_RESET;
        end else begin
            if (wr_pie) begin
                peripheral_interrupt_enable <= w_data[7:0] & `IEC_PIE_WMASK;
            end
            if (wr_config) begin
                ext_edge_select <= w_data[`IEC_EDGE_SEL_BIT];
            end
            if (wr_mask) begin
                event_mask <= w_data[`IEC_EVT_W-1:0];
            end
        end
    end

    // sticky event status, write one to clear, a new event wins
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            event_status <= `IEC_STATUS_RESET;
            irq <= 1'b0;
            core_irq <= 1'b0;
        end else begin
            event_status <= evt_set | (event_status & ~(wr_status ? w_data[`IEC_EVT_W-1:0] : 3'h0));
            irq <= |(event_status & event_mask);
            core_irq <= next_core_irq;
        end
    end

    // write address and data channels, taken in either order
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_idx <= 10'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IEC_RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            s_axi_awready <= !next_aw_full;
            s_axi_wready <= !next_w_full;
            if (hs_aw) begin
                aw_idx <= s_axi_awaddr[`IEC_ADDR_W-1:2];
            end
            if (hs_w) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                case (aw_idx)
                    `IEC_IDX_INTCTL_LO, `IEC_IDX_INTCTL_HI, `IEC_IDX_PIE, `IEC_IDX_CONFIG,
                    `IEC_IDX_STATUS, `IEC_IDX_MASK, `IEC_IDX_TIMER: begin
                        s_axi_bresp <= `IEC_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `IEC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read data depends on the index only; reads have no side effects
    always @* begin
        next_rdata = 32'h0000_0000;
        next_rresp = `IEC_RESP_OKAY;
        case (ar_idx)
            `IEC_IDX_INTCTL_LO, `IEC_IDX_INTCTL_HI: begin
                next_rdata = {24'h00_0000, interrupt_control};
            end
            `IEC_IDX_PIE: begin
                next_rdata = {24'h00_0000, peripheral_interrupt_enable};
            end
            `IEC_IDX_CONFIG: begin
                next_rdata = {31'h0000_0000, ext_edge_select};
            end
            `IEC_IDX_STATUS: begin
                next_rdata = {29'h0000_0000, event_status};
            end
            `IEC_IDX_MASK: begin
                next_rdata = {29'h0000_0000, event_mask};
            end
            `IEC_IDX_TIMER: begin
                next_rdata = {24'h00_0000, timer_zero_count};
            end
            default: begin
                next_rresp = `IEC_RESP_SLVERR;
            end
        endcase
    end

    // read channel, data captured at the address handshake
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `IEC_RESP_OKAY;
        end else begin
            s_axi_rvalid <= next_rvalid;
            s_axi_arready <= !next_rvalid;
            if (hs_ar) begin
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp;
            end
        end
    end

endmodule
`default_nettype wire
